// ---- design/drs_dma_top.sv ----
`timescale 1ns/1ns
module drs_dma_top (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	input wire logic ce,
	// register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	// request sources
	input wire logic [1:0] ext_req,
	input wire logic [3:0] periph_tx_req,
	input wire logic [3:0] periph_rx_req,
	// system events
	input wire logic nmi_in,
	// transfer bus side
	input wire logic unit_done,
	input wire logic addr_err,
	output logic unit_req,
	output logic [1:0] unit_ch,
	output logic [1:0] unit_size,
	output logic unit_burst,
	// cpu interrupts
	output logic [3:0] transfer_end_interrupt
);
	typedef struct packed {
		logic [15:0] sel01;
		logic [15:0] sel23;
		logic [3:0][11:0] ctl;
		logic [3:0][23:0] cnt;
		logic master_enable;
		logic nmi_flag;
		logic address_error_flag;
		logic nmi_seen;
		logic ae_seen;
		logic [1:0] pri;
		drs_pkg::drs_state_type st;
		logic [1:0] ch;
		logic [1:0] last;
		logic xfer;
		logic [1:0] size;
		logic burst;
		logic [3:0] irq;
		logic [31:0] rdata;
	} drs_top_state_type;

	drs_top_state_type s_q;
	drs_top_state_type s_d;
	logic [3:0] chan_ok;
	logic [3:0] raw_req;
	logic [3:0] req_vec;
	logic grant_valid;
	logic [1:0] grant_ch;
	logic [23:0] cnt_cur;
	logic [23:0] cnt_next;

	// eight-bit source code for a channel from the selector pair
	function automatic logic [7:0] sel_code(input logic [15:0] s01, input logic [15:0] s23,
		input logic [1:0] ch);
		logic [15:0] s;
		s = ch[1] ? s23 : s01;
		return ch[0] ? s[drs_pkg::SEL_ODD_LO +: drs_pkg::SEL_CODE_W]
			: s[0 +: drs_pkg::SEL_CODE_W];
	endfunction

	// request line picked out by module and register identifiers
	function automatic logic periph_hit(input logic [7:0] code, input logic [3:0] tx,
		input logic [3:0] rx);
		logic [3:0] onehot;
		logic hit;
		case (code[7:2])
			drs_pkg::MID_PORT0: onehot = 4'h1;
			drs_pkg::MID_PORT1: onehot = 4'h2;
			drs_pkg::MID_PORT2: onehot = 4'h4;
			drs_pkg::MID_SIFM: onehot = 4'h8;
			default: onehot = 4'h0;
		endcase
		// other lines are masked away entirely
		case (code[1:0])
			drs_pkg::RID_TX: hit = |(onehot & tx);
			drs_pkg::RID_RX: hit = |(onehot & rx);
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// word address of a per-channel register
	function automatic logic [7:0] ch_addr(input logic [7:0] base, input logic [1:0] ch);
		return 8'(base + {4'h0, ch, 2'b00});
	endfunction

	// enable qualification and request source selection per channel
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			chan_ok[i] = s_q.ctl[i][drs_pkg::CTL_EN] & s_q.master_enable
				& ~s_q.ctl[i][drs_pkg::CTL_TE] & ~s_q.address_error_flag
				& ~s_q.nmi_flag;
			case (s_q.ctl[i][drs_pkg::CTL_RS_LO +: 4])
				drs_pkg::RS_AUTO: raw_req[i] = 1'b1;
				// pins only reach the two low channels
				drs_pkg::RS_EXT: raw_req[i] = (i < 2) ? ext_req[i % 2] : 1'b0;
				drs_pkg::RS_PERIPH: raw_req[i] = periph_hit(sel_code(s_q.sel01, s_q.sel23,
					2'(i)), periph_tx_req, periph_rx_req);
				default: raw_req[i] = 1'b0;
			endcase
		end
		req_vec = chan_ok & raw_req;
	end

	drs_prio_arb u_arb (
		.req(req_vec),
		.mode(s_q.pri),
		.last(s_q.last),
		.grant_valid(grant_valid),
		.grant_ch(grant_ch)
	);

	assign cnt_cur = s_q.cnt[s_q.ch];
	assign cnt_next = 24'(cnt_cur - drs_pkg::CNT_ONE);

	// next state: hardware sequencing first, software writes, then flag sets
	always_comb begin
		s_d = s_q;
		s_d.irq = 4'h0;
		s_d.rdata = 32'h0000_0000;
		// sequencer
		case (s_q.st)
			drs_pkg::ST_IDLE: begin
				if (grant_valid) begin
					s_d.st = drs_pkg::ST_BUSY;
					s_d.ch = grant_ch;
					s_d.xfer = 1'b1;
					s_d.size = s_q.ctl[grant_ch][drs_pkg::CTL_TS_LO +: 2];
					s_d.burst = s_q.ctl[grant_ch][drs_pkg::CTL_BURST];
				end
			end
			drs_pkg::ST_BUSY: begin
				if (addr_err) begin
					// bus fault kills the unit at once
					s_d.st = drs_pkg::ST_IDLE;
					s_d.xfer = 1'b0;
				end else if (unit_done) begin
					s_d.cnt[s_q.ch] = cnt_next;
					s_d.last = s_q.ch;
					if (cnt_next == drs_pkg::CNT_RESET) begin
						s_d.ctl[s_q.ch][drs_pkg::CTL_TE] = 1'b1;
						s_d.st = drs_pkg::ST_IDLE;
						s_d.xfer = 1'b0;
					end else if (s_q.burst && req_vec[s_q.ch] && !nmi_in) begin
						// burst keeps the bus for the next unit
						s_d.st = drs_pkg::ST_BUSY;
					end else begin
						// cycle steal hands the bus back each unit
						s_d.st = drs_pkg::ST_IDLE;
						s_d.xfer = 1'b0;
					end
				end else if (!s_q.master_enable || !s_q.ctl[s_q.ch][drs_pkg::CTL_EN]) begin
					s_d.st = drs_pkg::ST_IDLE;
					s_d.xfer = 1'b0;
				end
			end
			default: begin
				s_d.st = drs_pkg::ST_IDLE;
				s_d.xfer = 1'b0;
			end
		endcase
		// register writes
		if (wr_en) begin
			if (addr == drs_pkg::OFF_SEL01)
				s_d.sel01 = wr_data[15:0];
			if (addr == drs_pkg::OFF_SEL23)
				s_d.sel23 = wr_data[15:0];
			if (addr == drs_pkg::OFF_OPREG) begin
				s_d.master_enable = wr_data[drs_pkg::OP_ME];
				s_d.pri = wr_data[drs_pkg::OP_PR_LO +: 2];
				// writing 1 never sets; 0 clears only after a read of 1
				if (!wr_data[drs_pkg::OP_NMI] && s_q.nmi_seen) begin
					s_d.nmi_flag = 1'b0;
					s_d.nmi_seen = 1'b0;
				end
				if (!wr_data[drs_pkg::OP_AE] && s_q.ae_seen) begin
					s_d.address_error_flag = 1'b0;
					s_d.ae_seen = 1'b0;
				end
			end
			for (int i = 0; i < 4; i++) begin
				if (addr == ch_addr(drs_pkg::OFF_CTL_BASE, 2'(i))) begin
					s_d.ctl[i] = {wr_data[11:2], s_q.ctl[i][drs_pkg::CTL_TE]
						& wr_data[drs_pkg::CTL_TE], wr_data[drs_pkg::CTL_EN]};
				end
				if (addr == ch_addr(drs_pkg::OFF_CNT_BASE, 2'(i)))
					s_d.cnt[i] = wr_data[23:0];
			end
		end
		// a completion in the clear cycle still sets the end flag
		if (s_q.st == drs_pkg::ST_BUSY && !addr_err && unit_done
			&& cnt_next == drs_pkg::CNT_RESET)
			s_d.ctl[s_q.ch][drs_pkg::CTL_TE] = 1'b1;
		// event flags: set beats clear, nmi flags even when idle
		if (nmi_in)
			s_d.nmi_flag = 1'b1;
		if (addr_err && s_q.st == drs_pkg::ST_BUSY)
			s_d.address_error_flag = 1'b1;
		// reads
		if (rd_en) begin
			if (addr == drs_pkg::OFF_SEL01)
				s_d.rdata = {16'h0000, s_q.sel01};
			if (addr == drs_pkg::OFF_SEL23)
				s_d.rdata = {16'h0000, s_q.sel23};
			if (addr == drs_pkg::OFF_OPREG) begin
				s_d.rdata = {22'h000000, s_q.pri, 5'h00, s_q.address_error_flag,
					s_q.nmi_flag, s_q.master_enable};
				// arm the clear for flags seen at 1
				if (s_q.nmi_flag)
					s_d.nmi_seen = 1'b1;
				if (s_q.address_error_flag)
					s_d.ae_seen = 1'b1;
			end
			for (int i = 0; i < 4; i++) begin
				if (addr == ch_addr(drs_pkg::OFF_CTL_BASE, 2'(i)))
					s_d.rdata = {20'h00000, s_q.ctl[i]};
				if (addr == ch_addr(drs_pkg::OFF_CNT_BASE, 2'(i)))
					s_d.rdata = {8'h00, s_q.cnt[i]};
			end
		end
		// completion interrupt is a level while end flag and enable stand
		for (int i = 0; i < 4; i++)
			s_d.irq[i] = s_d.ctl[i][drs_pkg::CTL_TE] & s_d.ctl[i][drs_pkg::CTL_IE];
	end

	// single state register; clock enable low freezes everything
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_q.sel01 <= drs_pkg::SEL_RESET;
			s_q.sel23 <= drs_pkg::SEL_RESET;
			s_q.ctl <= {4{drs_pkg::CTL_RESET}};
			s_q.cnt <= {4{drs_pkg::CNT_RESET}};
			s_q.master_enable <= 1'b0;
			s_q.nmi_flag <= 1'b0;
			s_q.address_error_flag <= 1'b0;
			s_q.nmi_seen <= 1'b0;
			s_q.ae_seen <= 1'b0;
			s_q.pri <= drs_pkg::PRI_FIXED0;
			s_q.st <= drs_pkg::ST_IDLE;
			s_q.ch <= 2'h0;
			s_q.last <= drs_pkg::LAST_RESET;
			s_q.xfer <= 1'b0;
			s_q.size <= 2'h0;
			s_q.burst <= 1'b0;
			s_q.irq <= 4'h0;
			s_q.rdata <= 32'h0000_0000;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state register
	assign rd_data = s_q.rdata;
	assign unit_req = s_q.xfer;
	assign unit_ch = s_q.ch;
	assign unit_size = s_q.size;
	assign unit_burst = s_q.burst;
	assign transfer_end_interrupt = s_q.irq;

	// checks run only on enabled clock edges, so a frozen block never trips them
	default clocking cb @(posedge clock iff ce);
	endclocking
	default disable iff (!rst_b);

	a_sel_write: assert property (wr_en && addr == drs_pkg::OFF_SEL23 |=>
		s_q.sel23 == $past(wr_data[15:0]))
		else $error("selector 2/3 did not take write");
	a_start_enabled: assert property ($rose(s_q.xfer) |->
		|($past(req_vec) & (4'h1 << s_q.ch)))
		else $error("unit started on a channel not enabled");
	a_count_dec: assert property (s_q.st == drs_pkg::ST_BUSY && unit_done && !addr_err
		&& !wr_en |=> s_q.cnt[$past(s_q.ch)] == 24'($past(cnt_cur) - drs_pkg::CNT_ONE))
		else $error("count not decremented by one");
	a_zero_end: assert property (s_q.st == drs_pkg::ST_BUSY && unit_done && !addr_err
		&& cnt_cur == drs_pkg::CNT_ONE |=> !s_q.xfer && s_q.ctl[$past(s_q.ch)][drs_pkg::CTL_TE])
		else $error("count zero did not end the channel");
	a_end_irq: assert property (s_q.ctl[0][drs_pkg::CTL_TE] && s_q.ctl[0][drs_pkg::CTL_IE]
		|-> s_q.irq[0])
		else $error("end interrupt missing on channel 0");
	a_err_abort: assert property (s_q.xfer && addr_err |=> !s_q.xfer ##1 !s_q.xfer)
		else $error("address error did not stop transfers");
	a_me_abort: assert property (!s_q.master_enable && !unit_done |=> !$rose(s_q.xfer))
		else $error("transfer started with master enable clear");
	a_nmi_flag: assert property (nmi_in |=> s_q.nmi_flag)
		else $error("nmi flag not set");
	a_flag_hold: assert property (s_q.address_error_flag && !(wr_en && addr ==
		drs_pkg::OFF_OPREG) |=> s_q.address_error_flag)
		else $error("address error flag cleared without a write");
	// error flags hold until software clears them and keep every channel quiet
	a_nmi_hold: assert property (
		s_q.nmi_flag && !(wr_en && addr == drs_pkg::OFF_OPREG) |=> s_q.nmi_flag)
		else $error("nmi flag cleared without a write");
	a_flag_block: assert property (
		s_q.nmi_flag || s_q.address_error_flag |-> req_vec == 4'h0)
		else $error("request passed while an error flag stands");
	a_end_block: assert property (
		grant_valid |-> !s_q.ctl[grant_ch][drs_pkg::CTL_TE])
		else $error("channel granted with its end flag set");
	a_me_block: assert property (
		!s_q.master_enable |-> !grant_valid)
		else $error("grant while master enable is clear");
	// request sources as seen per channel
	a_auto_req: assert property (
		s_q.ctl[2][drs_pkg::CTL_RS_LO +: 4] == drs_pkg::RS_AUTO |-> raw_req[2])
		else $error("auto request missing on channel 2");
	a_ext_pin: assert property (
		s_q.ctl[0][drs_pkg::CTL_RS_LO +: 4] == drs_pkg::RS_EXT |-> raw_req[0] == ext_req[0])
		else $error("external pin not followed on channel 0");
	a_periph_pick: assert property (
		s_q.ctl[1][drs_pkg::CTL_RS_LO +: 4] == drs_pkg::RS_PERIPH
		&& s_q.sel01[drs_pkg::SEL_ODD_LO +: drs_pkg::SEL_CODE_W]
		== {drs_pkg::MID_PORT1, drs_pkg::RID_RX} |-> raw_req[1] == periph_rx_req[1])
		else $error("channel 1 did not follow its selected receive line");
	// bus hold and release around a finished or interrupted unit
	a_steal_gap: assert property (
		s_q.xfer && !s_q.burst && unit_done && !addr_err |=> !s_q.xfer)
		else $error("cycle steal kept the bus after a unit");
	a_burst_hold: assert property (
		s_q.xfer && s_q.burst && unit_done && !addr_err && !nmi_in
		&& cnt_cur != drs_pkg::CNT_ONE && req_vec[s_q.ch] |=> s_q.xfer)
		else $error("burst dropped the bus with requests pending");
	a_nmi_finish: assert property (
		s_q.xfer && nmi_in && !unit_done && !addr_err && s_q.master_enable
		&& s_q.ctl[s_q.ch][drs_pkg::CTL_EN] |=> s_q.xfer)
		else $error("nmi cut a unit short");
	a_en_abort: assert property (
		s_q.xfer && !unit_done && !addr_err
		&& !s_q.ctl[s_q.ch][drs_pkg::CTL_EN] |=> !s_q.xfer)
		else $error("channel enable clear did not stop the unit");
	// completion interrupt and fixed arbitration orders
	a_irq_rise: assert property (
		s_q.st == drs_pkg::ST_BUSY && unit_done && !addr_err && !wr_en
		&& cnt_cur == drs_pkg::CNT_ONE && s_q.ctl[s_q.ch][drs_pkg::CTL_IE]
		|=> s_q.irq[$past(s_q.ch)])
		else $error("completion interrupt not raised");
	a_fixed_top: assert property (
		s_q.pri == drs_pkg::PRI_FIXED0 && req_vec[0] |-> grant_ch == 2'h0)
		else $error("fixed order did not favour channel 0");
	a_fixed_alt: assert property (
		s_q.pri == drs_pkg::PRI_FIXED1 && req_vec[2] && !req_vec[0] |-> grant_ch == 2'h2)
		else $error("second fixed order did not favour channel 2");
endmodule // drs_dma_top

// ---- design/drs_prio_arb.sv ----
`timescale 1ns/1ns
module drs_prio_arb (
	// requests and mode
	input wire logic [3:0] req,
	input wire logic [1:0] mode,
	input wire logic [1:0] last,
	// grant
	output logic grant_valid,
	output logic [1:0] grant_ch
);
	// channel at position k of the current priority order
	function automatic logic [1:0] order_at(input logic [1:0] m, input logic [1:0] l,
		input logic [1:0] k);
		logic [1:0] r;
		r = k;
		case (m)
			drs_pkg::PRI_FIXED1: begin
				// 0 > 2 > 3 > 1
				case (k)
					2'h0: r = 2'h0;
					2'h1: r = 2'h2;
					2'h2: r = 2'h3;
					default: r = 2'h1;
				endcase
			end
			// last served drops to the bottom; rotation wraps in 2 bits
			drs_pkg::PRI_RR: r = 2'(l + k + 2'h1);
			// prohibited 10 falls back to plain fixed order
			default: r = k;
		endcase
		return r;
	endfunction

	// scan from the bottom of the order up, last requester found wins
	always_comb begin
		grant_valid = 1'b0;
		grant_ch = 2'h0;
		for (int k = 3; k >= 0; k--) begin
			if (req[order_at(mode, last, 2'(k))]) begin
				grant_valid = 1'b1;
				grant_ch = order_at(mode, last, 2'(k));
			end
		end
	end
endmodule // drs_prio_arb

// ---- inc/drs_pkg.sv ----
package drs_pkg;
	// register bus geometry and map
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_SEL01 = 8'h00;
	localparam logic [7:0] OFF_SEL23 = 8'h04;
	localparam logic [7:0] OFF_OPREG = 8'h08;
	localparam logic [7:0] OFF_CTL_BASE = 8'h10;
	localparam logic [7:0] OFF_CNT_BASE = 8'h20;
	localparam logic [15:0] SEL_RESET = 16'h0000;
	// selector layout
	localparam int SEL_ODD_LO = 8;
	localparam int SEL_CODE_W = 8;
	// channel control layout
	localparam int CTL_W = 12;
	localparam int CTL_EN = 0;
	localparam int CTL_TE = 1;
	localparam int CTL_IE = 2;
	localparam int CTL_TS_LO = 3;
	localparam int CTL_BURST = 5;
	localparam int CTL_RS_LO = 8;
	localparam logic [11:0] CTL_RESET = 12'h000;
	// operation register layout
	localparam int OP_ME = 0;
	localparam int OP_NMI = 1;
	localparam int OP_AE = 2;
	localparam int OP_PR_LO = 8;
	// transfer count
	localparam int CNT_W = 24;
	localparam logic [23:0] CNT_RESET = 24'h000000;
	localparam logic [23:0] CNT_ONE = 24'h000001;
	// resource select codes
	localparam logic [3:0] RS_EXT = 4'h0;
	localparam logic [3:0] RS_AUTO = 4'h4;
	localparam logic [3:0] RS_PERIPH = 4'h8;
	// peripheral module and register identifiers
	localparam logic [5:0] MID_PORT0 = 6'h08;
	localparam logic [5:0] MID_PORT1 = 6'h09;
	localparam logic [5:0] MID_PORT2 = 6'h0A;
	localparam logic [5:0] MID_SIFM = 6'h14;
	localparam logic [1:0] RID_TX = 2'h1;
	localparam logic [1:0] RID_RX = 2'h2;
	// priority modes
	localparam logic [1:0] PRI_FIXED0 = 2'h0;
	localparam logic [1:0] PRI_FIXED1 = 2'h1;
	localparam logic [1:0] PRI_RR = 2'h3;
	localparam logic [1:0] LAST_RESET = 2'h3;
	// transfer sequencer states, gray along idle-busy
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BUSY = 2'b01
	} drs_state_type;
endpackage

// ---- test/drs_dma_top_tb.sv ----
`timescale 1ns/1ns
module drs_dma_top_tb;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wr_data = 32'h0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic nmi_in = 1'b0;
	logic [7:0] src_on = 8'h00;
	logic [3:0] lat = 4'h2;
	logic fail_next = 1'b0;
	logic [1:0] ext_req = 2'h0;
	logic [31:0] rd_data;
	logic [3:0] tx_req, rx_req, irq;
	logic unit_done, addr_err, unit_req, unit_burst;
	logic [1:0] unit_ch, unit_size;
	int error_cnt = 0;
	int checks_done = 0;
	// 10 MHz system clock
	always #50 clock = ~clock;
	drs_dma_top dut_u (.clock(clock), .rst_b(rst_b), .ce(1'b1), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.ext_req(ext_req), .periph_tx_req(tx_req), .periph_rx_req(rx_req),
		.nmi_in(nmi_in), .unit_done(unit_done), .addr_err(addr_err),
		.unit_req(unit_req), .unit_ch(unit_ch), .unit_size(unit_size),
		.unit_burst(unit_burst), .transfer_end_interrupt(irq));
	drs_periph_model far_u (.clock(clock), .rst_b(rst_b), .src_on(src_on),
		.lat(lat), .fail_next(fail_next), .unit_req(unit_req),
		.unit_done(unit_done), .addr_err(addr_err),
		.periph_tx_req(tx_req), .periph_rx_req(rx_req));
	// verdict and end of run, also reached by an expired wait
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
			error_cnt++;
		end
	endtask
	// one-cycle strobes, held across exactly one sampling edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		@(negedge clock);
		chk(rd_data, e);
	endtask
	task automatic wait_unit(input logic [1:0] ch);
		int n;
		n = 0;
		while (unit_req !== 1'b1 && n < 60) begin
			@(negedge clock);
			n++;
		end
		if (n >= 60) begin
			chk(32'h0, 32'h1);
			give_verdict();
		end
		chk({30'h0, unit_ch}, {30'h0, ch});
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			@(negedge clock);
			chk({31'h0, unit_req}, 32'h0);
		end
	endtask
	task automatic t_regs();
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		wr(8'hFC, 32'hFFFF_FFFF);
		rd(8'hFC, 32'h0);
		wr(8'h04, 32'hFFFF_5221);
		rd(8'h04, 32'h0000_5221);
		$display("test regs done");
	endtask
	task automatic t_periph();
		int n;
		int units;
		wr(8'h00, 32'h0000_2651);
		rd(8'h00, 32'h0000_2651);
		wr(8'h10, 32'h0000_0001);
		wr(8'h14, 32'h0000_0815);
		wr(8'h24, 32'h0000_0002);
		wr(8'h08, 32'h0000_0001);
		@(posedge clock);
		src_on <= 8'h8A;
		idle(20);
		@(posedge clock);
		src_on <= 8'hAA;
		wait_unit(2'h1);
		chk({30'h0, unit_size}, 32'h2);
		chk({31'h0, unit_burst}, 32'h0);
		units = 0;
		n = 0;
		while (irq !== 4'h2 && n < 200) begin
			@(negedge clock);
			if (unit_done === 1'b1) begin
				units++;
			end
			n++;
		end
		chk(units, 2);
		chk({28'h0, irq}, 32'h2);
		rd(8'h24, 32'h0);
		rd(8'h14, 32'h0000_0817);
		idle(10);
		wr(8'h10, 32'h0);
		@(posedge clock);
		src_on <= 8'h00;
		$display("test periph done");
	endtask
	task automatic t_abort();
		wr(8'h28, 32'h3);
		wr(8'h18, 32'h0000_0401);
		wait_unit(2'h2);
		@(posedge clock);
		fail_next <= 1'b1;
		repeat (8) @(negedge clock);
		chk({31'h0, unit_req}, 32'h0);
		@(posedge clock);
		fail_next <= 1'b0;
		lat <= 4'hF;
		wr(8'h08, 32'h1);
		rd(8'h08, 32'h5);
		wr(8'h08, 32'h1);
		rd(8'h08, 32'h1);
		wait_unit(2'h2);
		wr(8'h18, 32'h0000_0400);
		repeat (2) @(negedge clock);
		chk({31'h0, unit_req}, 32'h0);
		$display("test abort done");
	endtask
	// both channels become ready at the same edge, when master enable rises
	task automatic t_prio();
		// round robin: channel 1 was served last, so channel 2 leads
		logic [1:0] mode [3] = '{2'h0, 2'h1, 2'h3};
		logic [1:0] first [3] = '{2'h1, 2'h2, 2'h2};
		for (int i = 0; i < 3; i++) begin
			wr(8'h08, 32'h0);
			wr(8'h24, 32'h1);
			wr(8'h28, 32'h1);
			wr(8'h14, 32'h0000_0401);
			wr(8'h18, 32'h0000_0401);
			wr(8'h08, {22'h0, mode[i], 8'h01});
			wait_unit(first[i]);
			wr(8'h08, {22'h0, mode[i], 8'h00});
			repeat (2) @(negedge clock);
			chk({31'h0, unit_req}, 32'h0);
		end
		$display("test prio done");
	endtask
	// external pin on channel 0 in burst mode keeps the bus for both units
	task automatic t_ext();
		int n;
		int units;
		@(posedge clock);
		lat <= 4'h2;
		wr(8'h14, 32'h0000_0400);
		wr(8'h18, 32'h0000_0400);
		wr(8'h20, 32'h0000_0002);
		wr(8'h10, 32'h0000_0021);
		wr(8'h08, 32'h0000_0001);
		idle(5);
		@(posedge clock);
		ext_req <= 2'h1;
		wait_unit(2'h0);
		chk({31'h0, unit_burst}, 32'h1);
		units = 0;
		n = 0;
		while (unit_req === 1'b1 && n < 60) begin
			@(negedge clock);
			if (unit_done === 1'b1) begin
				units++;
			end
			n++;
		end
		chk(units, 2);
		chk({28'h0, irq}, 32'h0);
		rd(8'h20, 32'h0);
		rd(8'h10, 32'h0000_0023);
		wr(8'h08, 32'h0);
		@(posedge clock);
		ext_req <= 2'h0;
		wr(8'h10, 32'h0);
		$display("test ext done");
	endtask
	// writing 1 over the set flag must not clear it; a unit in flight still finishes
	task automatic t_nmi();
		wr(8'h24, 32'h1);
		wr(8'h14, 32'h0000_0401);
		wr(8'h18, 32'h0000_0401);
		@(posedge clock);
		nmi_in <= 1'b1;
		@(posedge clock);
		nmi_in <= 1'b0;
		rd(8'h08, 32'h2);
		wr(8'h08, 32'h3);
		idle(10);
		rd(8'h08, 32'h3);
		wr(8'h08, 32'h1);
		wait_unit(2'h1);
		@(posedge clock);
		nmi_in <= 1'b1;
		@(posedge clock);
		nmi_in <= 1'b0;
		repeat (6) @(negedge clock);
		chk({31'h0, unit_req}, 32'h0);
		rd(8'h24, 32'h0);
		rd(8'h14, 32'h0000_0403);
		idle(5);
		$display("test nmi done");
	endtask
	initial begin
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		t_regs();
		t_periph();
		t_abort();
		t_prio();
		t_ext();
		t_nmi();
		give_verdict();
	end
endmodule // drs_dma_top_tb

// ---- test/drs_periph_model.sv ----
`timescale 1ns/1ns
module drs_periph_model (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// bench control
	input wire logic [7:0] src_on,
	input wire logic [3:0] lat,
	input wire logic fail_next,
	// bus side of the block
	input wire logic unit_req,
	output logic unit_done,
	output logic addr_err,
	// request lines, rx in the upper nibble of src_on
	output logic [3:0] periph_tx_req,
	output logic [3:0] periph_rx_req
);
	logic [3:0] wait_q;
	// request levels stay up while a source wants service
	assign periph_tx_req = src_on[3:0];
	assign periph_rx_req = src_on[7:4];
	// one answer per unit after lat cycles; a large lat models a stalled bus
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wait_q <= 4'h0;
			unit_done <= 1'b0;
			addr_err <= 1'b0;
		end else begin
			unit_done <= 1'b0;
			addr_err <= 1'b0;
			wait_q <= 4'h0;
			if (unit_req && !unit_done && !addr_err) begin
				if (wait_q >= lat) begin
					unit_done <= !fail_next;
					addr_err <= fail_next;
				end else begin
					wait_q <= wait_q + 4'h1;
				end
			end
		end
	end
endmodule // drs_periph_model
